// File: design/fail_check.sv
// Combinational failure classifier for one finished embedded operation.
// Assumes operation inputs stay stable while the operation is busy.
`timescale 1ns/100ps
`include "flash_status_map.svh"

module fail_check
	import flash_status_pkg::*;
(
	input  wire logic       op_program,
	input  wire logic       op_erase,
	input  wire logic       op_reg_write,
	input  wire logic       op_pwd_write,
	input  wire logic       target_protected,
	input  wire logic       verify_fail,
	input  wire logic       cfr_bits_change,
	input  wire logic [8:0] prot_cfg,
	output logic            prg_fail,
	output logic            ers_fail
);

	logic cfr_locked;

	always_comb
	begin
		cfr_locked = !prot_cfg[`BIT_ASP_A] || !prot_cfg[`BIT_ASP_B];
		prg_fail = (op_program && verify_fail)
			|| (op_program && target_protected)
			|| (op_reg_write && cfr_locked && cfr_bits_change)
			|| (op_pwd_write && prot_cfg[`BIT_PWD_MODE]);
		ers_fail = (op_erase && verify_fail)
			|| (op_erase && target_protected)
			|| (op_reg_write && verify_fail);
	end

endmodule

// File: design/flash_busy_error_status.sv
// Busy and program/erase failure status of the flash's embedded operations.
// Assumes a command decoder presents one-cycle op_start pulses with op_kind,
// and software on the plain register port reads status and interrupt state.
//
// Operation
// - The busy flag reads 1 during an embedded operation and 0 in standby.
// - The failure flags change only while the busy flag is set.
// - Programming that cannot turn a 1 into a 0 sets the program failure flag.
// - Programming a protected address sets the program failure flag.
// - With a protect-config bit 2 or 1 at 0, changing config bits 6:2 fails.
// - In password mode a password register update sets the program failure.
// - An erase that leaves any bit not 1 sets the erase failure flag.
// - Erasing a protected region sets the erase failure flag.
// - A register write whose erase step fails sets the erase failure flag.
// - Status is invalid during any reset or deep power down exit.
// - The busy flag is volatile, read only, and resets to 0.
// - Erase failure clears only by the clear command or a reset.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "flash_status_map.svh"

module flash_busy_error_status
	import flash_status_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       op_start,
	input  wire op_kind_t   op_kind,
	input  wire logic       target_protected,
	input  wire logic       verify_fail,
	input  wire logic       cfr_bits_change,
	input  wire logic       boot_fail,
	input  wire logic       config_fail,
	input  wire logic       reset_event,
	input  wire logic       dpd_exit,
	input  wire logic [3:0] reg_addr,
	input  wire logic [8:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [8:0]      reg_rdata,
	output logic            device_busy_flag,
	output logic            program_fail_flag,
	output logic            erase_fail_flag,
	output logic            op_accept,
	output logic            op_refused,
	output logic            status_valid,
	output logic            irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		seq_state_t seq;
		op_kind_t   kind;
		logic       busy;
		// Sticky failure flags; only clear or a reset drops them
		logic       prg_fail;
		logic       ers_fail;
		logic       accept;
		logic       refused;
		logic       valid;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic [8:0] prot_cfg;
		logic [8:0] rdata;
		logic       irq;
		logic       boot_seen;
	} status_state_t;

	status_state_t state_reg;
	status_state_t state_next;

	logic timer_start;
	logic timer_done;
	logic chk_prg;
	logic chk_ers;

	function automatic logic [8:0] status_word(input logic busy, input logic pf,
		input logic ef);
		logic [8:0] w;
		w = 9'h000;
		w[`BIT_BUSY] = busy;
		w[`BIT_PRG_FAIL] = pf;
		w[`BIT_ERS_FAIL] = ef;
		return w;
	endfunction

	// Only these kinds run the timer; clear and none never start one
	function automatic logic runs_timer(input op_kind_t k);
		return (k != OP_NONE) && (k != OP_CLEAR);
	endfunction

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// A fresh start reloads the count, so a run cut by a reset event is harmless
	op_timer i_op_timer
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (timer_start),
		.done    (timer_done)
	);

	// Classifier inputs count only in the timer's done cycle
	fail_check i_fail_check
	(
		.op_program       (state_reg.kind == OP_PROGRAM),
		.op_erase         (state_reg.kind == OP_ERASE),
		.op_reg_write     (state_reg.kind == OP_REG_WRITE),
		.op_pwd_write     (state_reg.kind == OP_PWD_WRITE),
		.target_protected (target_protected),
		.verify_fail      (verify_fail),
		.cfr_bits_change  (cfr_bits_change),
		.prot_cfg         (state_reg.prot_cfg),
		.prg_fail         (chk_prg),
		.ers_fail         (chk_ers)
	);

	assign timer_start = op_start && (state_reg.seq == ST_IDLE) && runs_timer(op_kind);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic [2:0] ev;
		logic       stale;
		ev = 3'h0;
		stale = reset_event || dpd_exit;
		state_next = state_reg;
		state_next.accept = 1'b0;
		state_next.refused = 1'b0;
		// Status not trustworthy through reset-like intervals
		state_next.valid = !stale;

		case (state_reg.seq)
			ST_IDLE:
			begin
				if (op_start && runs_timer(op_kind))
				begin
					state_next.seq = ST_BUSY;
					state_next.kind = op_kind;
					state_next.busy = 1'b1;
					state_next.accept = 1'b1;
				end
			end
			ST_BUSY:
			begin
				// Operation failures latch only in this busy window
				if (timer_done)
				begin
					state_next.prg_fail = state_reg.prg_fail | chk_prg;
					state_next.ers_fail = state_reg.ers_fail | chk_ers;
					if (chk_prg || chk_ers)
					begin
						state_next.seq = ST_FAULT;
						ev[`IRQ_PRG] = chk_prg;
						ev[`IRQ_ERS] = chk_ers;
					end
					else
					begin
						state_next.seq = ST_DONE;
					end
				end
				if (op_start)
					state_next.refused = 1'b1;
			end
			ST_DONE:
			begin
				// Extra cycle lets the done interrupt land with busy low
				state_next.seq = ST_IDLE;
				state_next.busy = 1'b0;
				state_next.kind = OP_NONE;
				ev[`IRQ_DONE] = 1'b1;
				if (op_start)
					state_next.refused = 1'b1;
			end
			ST_FAULT:
			begin
				// Only the clear command or a reset event leaves this state; host keeps order
				if (op_start && op_kind == OP_CLEAR)
				begin
					state_next.prg_fail = 1'b0;
					state_next.ers_fail = 1'b0;
					state_next.busy = 1'b0;
					state_next.seq = ST_IDLE;
					state_next.kind = OP_NONE;
					state_next.accept = 1'b1;
				end
				else if (op_start)
				begin
					state_next.refused = 1'b1;
				end
			end
			default:
			begin
				state_next.seq = ST_IDLE;
				state_next.busy = 1'b0;
			end
		endcase

		// Boot and configuration failures strike once, out of reset
		if (!state_reg.boot_seen && (boot_fail || config_fail))
		begin
			state_next.boot_seen = 1'b1;
			state_next.prg_fail = 1'b1;
			state_next.ers_fail = state_next.ers_fail | boot_fail;
			state_next.busy = 1'b1;
			state_next.seq = ST_FAULT;
			ev[`IRQ_PRG] = 1'b1;
			ev[`IRQ_ERS] = ev[`IRQ_ERS] | boot_fail;
		end

		// Register writes; set wins over write-one-to-clear
		if (reg_wr)
		begin
			case (reg_addr)
				`OFS_IRQ_STATUS:
					state_next.irq_status = state_reg.irq_status & ~reg_wdata[2:0];
				`OFS_IRQ_MASK:
					state_next.irq_mask = reg_wdata[2:0];
				// Lock settings must not move under a running operation
				`OFS_PROT_CFG:
					if (state_reg.seq == ST_IDLE)
						state_next.prot_cfg = reg_wdata;
				default:
					state_next.irq_mask = state_next.irq_mask;
			endcase
		end
		state_next.irq_status = state_next.irq_status | ev;

		// Read data stands only in the cycle after the strobe
		state_next.rdata = 9'h000;
		if (reg_rd)
		begin
			case (reg_addr)
				`OFS_STATUS:
					state_next.rdata = status_word(state_reg.busy,
						state_reg.prg_fail, state_reg.ers_fail);
				`OFS_IRQ_STATUS:
					state_next.rdata = {6'h00, state_reg.irq_status};
				`OFS_IRQ_MASK:
					state_next.rdata = {6'h00, state_reg.irq_mask};
				// Readback: bit0 in fault, bit1 status valid
				`OFS_CONTROL:
					state_next.rdata = {7'h00, state_reg.valid, state_reg.seq == ST_FAULT};
				`OFS_PROT_CFG:
					state_next.rdata = state_reg.prot_cfg;
				default:
					state_next.rdata = 9'h000;
			endcase
		end

		state_next.irq = |(state_next.irq_status & state_next.irq_mask);

		// A reset event, not dpd_exit, drops sequence, busy and failure flags back to standby
		if (reset_event)
		begin
			state_next.seq = ST_IDLE;
			state_next.busy = 1'b0;
			state_next.prg_fail = 1'b0;
			state_next.ers_fail = 1'b0;
			state_next.kind = OP_NONE;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= '0;
			// Lock bits come up set, so configuration writes start open
			state_reg.prot_cfg <= `RST_PROT_CFG;
			state_reg.irq_mask <= `RST_MASK;
			state_reg.busy <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign device_busy_flag = state_reg.busy;
	assign program_fail_flag = state_reg.prg_fail;
	assign erase_fail_flag = state_reg.ers_fail;
	assign op_accept = state_reg.accept;
	assign op_refused = state_reg.refused;
	assign status_valid = state_reg.valid;
	assign reg_rdata = state_reg.rdata;
	assign irq = state_reg.irq;

endmodule

// File: design/flash_status_map.svh
// Constants for the busy and failure status block: bit positions, resets, timing.
// Assumes inclusion by the package and by every design module of the block.
`ifndef FLASH_STATUS_MAP_SVH
`define FLASH_STATUS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_STATUS      4'h0
`define OFS_IRQ_STATUS  4'h1
`define OFS_IRQ_MASK    4'h2
`define OFS_CONTROL     4'h3
`define OFS_PROT_CFG    4'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_BUSY        0
`define BIT_PRG_FAIL    6
`define BIT_ERS_FAIL    5
`define BIT_ASP_A       2
`define BIT_ASP_B       1
`define BIT_PWD_MODE    8
`define CFR_LO          2
`define CFR_HI          6

// Interrupt status bits
`define IRQ_PRG         0
`define IRQ_ERS         1
`define IRQ_DONE        2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_MASK        3'h0
`define RST_PROT_CFG    9'h006

// ----------------------------------------
// Timing
// ----------------------------------------
`define OP_TIME_NS      1000
`define CLK_PERIOD_NS   100
`define OP_CYCLES       (`OP_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: design/flash_status_pkg.sv
// Types shared by the busy and failure status block.
// Assumes the map header is on the include path.
`include "flash_status_map.svh"

package flash_status_pkg;

	// Embedded operation kinds, as presented on op_kind
	typedef enum logic [2:0]
	{
		OP_NONE      = 3'h0,
		OP_PROGRAM   = 3'h1,
		OP_ERASE     = 3'h2,
		OP_REG_WRITE = 3'h3,
		OP_PWD_WRITE = 3'h4,
		OP_CLEAR     = 3'h5
	} op_kind_t;

	// Gray coded along idle -> busy -> done
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'h0,
		ST_BUSY  = 2'h1,
		ST_DONE  = 2'h3,
		ST_FAULT = 2'h2
	} seq_state_t;

endpackage

// File: design/op_timer.sv
// Countdown timer for the duration of an embedded operation.
// Assumes a start pulse only while idle; done pulses one cycle at expiry.
`timescale 1ns/100ps
`include "flash_status_map.svh"

module op_timer
	import flash_status_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic start,
	output logic      done
);

	typedef struct packed
	{
		logic [7:0] count;
		logic       run;
		logic       done;
	} timer_state_t;

	timer_state_t state_reg;
	timer_state_t state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.done = 1'b0;
		if (start)
		begin
			state_next.count = 8'(`OP_CYCLES - 1);
			state_next.run = 1'b1;
		end
		else if (state_reg.run)
		begin
			if (state_reg.count == 8'h00)
			begin
				state_next.run = 1'b0;
				state_next.done = 1'b1;
			end
			else
			begin
				state_next.count = state_reg.count - 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign done = state_reg.done;

endmodule

// File: testbench/flash_busy_error_status_bench.sv
// Self-checking bench for the busy and failure status block.
// Assumes the host model issues every operation request.
`timescale 1ns/100ps
`include "flash_status_map.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end

module flash_busy_error_status_bench
	import flash_status_pkg::*;
;
	logic       clk_sys, rst, op_start, target_protected, verify_fail, cfr_bits_change;
	logic       boot_fail, config_fail, reset_event, dpd_exit, reg_wr, reg_rd;
	logic       device_busy_flag, program_fail_flag, erase_fail_flag, op_accept;
	logic       op_refused, status_valid, irq, go, rude, acc, rf;
	logic [3:0] reg_addr;
	logic [8:0] reg_wdata, reg_rdata, d;
	op_kind_t   op_kind, kind;
	int         err_count, compares;

	flash_busy_error_status i_flash_busy_error_status
	(
		.clk_sys           (clk_sys),
		.rst               (rst),
		.op_start          (op_start),
		.op_kind           (op_kind),
		.target_protected  (target_protected),
		.verify_fail       (verify_fail),
		.cfr_bits_change   (cfr_bits_change),
		.boot_fail         (boot_fail),
		.config_fail       (config_fail),
		.reset_event       (reset_event),
		.dpd_exit          (dpd_exit),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_rdata         (reg_rdata),
		.device_busy_flag  (device_busy_flag),
		.program_fail_flag (program_fail_flag),
		.erase_fail_flag   (erase_fail_flag),
		.op_accept         (op_accept),
		.op_refused        (op_refused),
		.status_valid      (status_valid),
		.irq               (irq)
	);
	host_model i_host_model
	(
		.clk_sys   (clk_sys),
		.rst       (rst),
		.go        (go),
		.kind      (kind),
		.rude      (rude),
		.fail_seen (program_fail_flag | erase_fail_flag),
		.op_kind   (op_kind),
		.op_start  (op_start)
	);

	initial
	begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end
	// ----
	// Tasks
	// ----
	task wr(input logic [3:0] a, input logic [8:0] v);
		@(posedge clk_sys);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 0;
		#1;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task op(input op_kind_t k);
		@(posedge clk_sys);
		go <= 1;
		kind <= k;
		@(posedge clk_sys);
		go <= 0;
		acc = 0;
		rf = 0;
		repeat (4)
		begin
			@(posedge clk_sys);
			#1 acc |= op_accept;
			rf |= op_refused;
		end
	endtask
	task row(input op_kind_t k, input logic p, v, c, input logic [8:0] g,
		input logic ep, ee);
		wr(`OFS_PROT_CFG, g);
		@(posedge clk_sys);
		target_protected <= p;
		verify_fail <= v;
		cfr_bits_change <= c;
		op(k);
		`CHK("accept", 1'b1, acc)
		repeat (10) @(posedge clk_sys);
		#1;
		`CHK("flags", {ep, ee}, {program_fail_flag, erase_fail_flag})
		`CHK("busy", ep | ee, device_busy_flag)
		@(posedge clk_sys);
		{target_protected, verify_fail, cfr_bits_change} <= 0;
		if (ep | ee)
		begin
			rude <= 1;
			op(OP_PROGRAM);
			rude <= 0;
			`CHK("refused", 2'b01, {acc, rf})
			op(OP_CLEAR);
			`CHK("clr", 3'h0, {device_busy_flag, program_fail_flag, erase_fail_flag})
		end
		$display("row %0d done", k);
	endtask
	task t_regs;
		rd(`OFS_STATUS);
		`CHK("status", 9'h000, d)
		wr(`OFS_STATUS, 9'h1FF);
		rd(`OFS_STATUS);
		`CHK("ro", 9'h000, d)
		rd(`OFS_PROT_CFG);
		`CHK("prot", `RST_PROT_CFG, d)
		rd(4'hF);
		`CHK("unmapped", 9'h000, d)
		op(OP_PROGRAM);
		rd(`OFS_STATUS);
		`CHK("busy rd", 9'h001, d)
		repeat (8) @(posedge clk_sys);
		#1;
		`CHK("idle", 1'b0, device_busy_flag)
		rd(`OFS_STATUS);
		`CHK("ready rd", 9'h000, d)
		`CHK("masked", 1'b0, irq)
		wr(`OFS_IRQ_MASK, 9'h004);
		`CHK("irq", 1'b1, irq)
		wr(`OFS_IRQ_STATUS, 9'h004);
		`CHK("irq clr", 1'b0, irq)
		$display("regs done");
	endtask
	task t_resets;
		@(posedge clk_sys);
		verify_fail <= 1;
		op(OP_ERASE);
		repeat (10) @(posedge clk_sys);
		verify_fail <= 0;
		reset_event <= 1;
		@(posedge clk_sys);
		reset_event <= 0;
		dpd_exit <= 1;
		#1;
		`CHK("valid", 1'b0, status_valid)
		`CHK("reset", 2'b00, {device_busy_flag, erase_fail_flag})
		@(posedge clk_sys);
		dpd_exit <= 0;
		#1;
		`CHK("dpd", 1'b0, status_valid)
		@(posedge clk_sys);
		#1;
		`CHK("valid back", 1'b1, status_valid)
		$display("resets done");
	endtask
	task t_boot(input logic b, c, input logic [2:0] e);
		@(posedge clk_sys);
		rst <= 1;
		@(posedge clk_sys);
		rst <= 0;
		boot_fail <= b;
		config_fail <= c;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK("boot", e, {device_busy_flag, program_fail_flag, erase_fail_flag})
		rd(`OFS_IRQ_STATUS);
		`CHK("boot irq", {7'h00, e[0], e[1]}, d)
		rd(`OFS_CONTROL);
		`CHK("fault ctrl", 9'h003, d)
		@(posedge clk_sys);
		{boot_fail, config_fail} <= 0;
		op(OP_CLEAR);
		`CHK("boot clr", 1'b0, device_busy_flag)
		$display("boot done");
	endtask
	task stop_test;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----
	// Sequence
	// ----
	initial
	begin
		{go, rude, target_protected, verify_fail, cfr_bits_change} = 0;
		{boot_fail, config_fail, reset_event, dpd_exit, reg_wr, reg_rd} = 0;
		{reg_addr, reg_wdata, err_count, compares} = 0;
		kind = OP_NONE;
		rst = 1;
		repeat (20) @(posedge clk_sys);
		rst <= 0;
		t_regs;
		row(OP_PROGRAM, 0, 1, 0, 9'h006, 1, 0);
		row(OP_PROGRAM, 1, 0, 0, 9'h006, 1, 0);
		row(OP_REG_WRITE, 0, 0, 1, 9'h006, 0, 0);
		row(OP_REG_WRITE, 0, 0, 1, 9'h004, 1, 0);
		row(OP_REG_WRITE, 0, 0, 1, 9'h002, 1, 0);
		row(OP_PWD_WRITE, 0, 0, 0, 9'h006, 0, 0);
		row(OP_PWD_WRITE, 0, 0, 0, 9'h106, 1, 0);
		row(OP_ERASE, 0, 1, 0, 9'h006, 0, 1);
		row(OP_ERASE, 1, 0, 0, 9'h006, 0, 1);
		row(OP_REG_WRITE, 0, 1, 0, 9'h006, 0, 1);
		t_resets;
		t_boot(1, 0, 3'h7);
		t_boot(0, 1, 3'h6);
		stop_test;
	end
	// Run needs well under a thousand cycles
	initial
	begin
		#(3000 * 100);
		err_count++;
		stop_test;
	end
endmodule

bind flash_busy_error_status flash_busy_error_status_checker i_flash_busy_error_status_checker
(
	.clk_sys           (clk_sys),
	.rst               (rst),
	.op_start          (op_start),
	.op_kind           (op_kind),
	.reset_event       (reset_event),
	.dpd_exit          (dpd_exit),
	.reg_addr          (reg_addr),
	.reg_rd            (reg_rd),
	.reg_rdata         (reg_rdata),
	.device_busy_flag  (device_busy_flag),
	.program_fail_flag (program_fail_flag),
	.erase_fail_flag   (erase_fail_flag),
	.op_accept         (op_accept),
	.op_refused        (op_refused),
	.status_valid      (status_valid)
);

// File: testbench/flash_busy_error_status_checker.sv
// Port assertions for the busy and failure status block.
// Assumes binding onto the top module from the bench file.
`timescale 1ns/100ps
`include "flash_status_map.svh"

module flash_busy_error_status_checker
	import flash_status_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       op_start,
	input wire op_kind_t   op_kind,
	input wire logic       reset_event,
	input wire logic       dpd_exit,
	input wire logic [3:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [8:0] reg_rdata,
	input wire logic       device_busy_flag,
	input wire logic       program_fail_flag,
	input wire logic       erase_fail_flag,
	input wire logic       op_accept,
	input wire logic       op_refused,
	input wire logic       status_valid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic fl;
	logic go;
	assign fl = program_fail_flag | erase_fail_flag;
	// A reset pulse overrides any request in the same cycle
	assign go = op_start & ~reset_event;
	// ----
	// Checks
	// ----
	AST_ACCEPT: assert property (
		go && !device_busy_flag && op_kind inside {[OP_PROGRAM:OP_PWD_WRITE]}
		|=> op_accept && device_busy_flag) else $error("op not taken");
	AST_END: assert property (
		$rose(device_busy_flag) |-> ##[8:14] (!device_busy_flag || fl))
		else $error("op never ends");
	AST_FLAG_BUSY: assert property ($rose(fl) |-> device_busy_flag)
		else $error("flag set while idle");
	AST_FAIL_HOLD: assert property (fl |-> device_busy_flag)
		else $error("standby with failure");
	AST_REFUSE: assert property (
		go && device_busy_flag && !(op_kind inside {OP_NONE, OP_CLEAR})
		|=> op_refused && !op_accept) else $error("busy op not refused");
	AST_ERS_HOLD: assert property (
		erase_fail_flag && !reset_event && !(op_start && op_kind == OP_CLEAR)
		|=> erase_fail_flag) else $error("erase flag lost");
	AST_CLEAR: assert property (
		go && op_kind == OP_CLEAR && fl
		|=> op_accept && !device_busy_flag && !fl) else $error("clear failed");
	AST_INVALID: assert property ((reset_event || dpd_exit) |=> !status_valid)
		else $error("status valid in reset");
	AST_RD: assert property (
		reg_rd && reg_addr == `OFS_STATUS |=>
		reg_rdata[`BIT_BUSY] == $past(device_busy_flag)
		&& reg_rdata[`BIT_PRG_FAIL] == $past(program_fail_flag))
		else $error("status read wrong");
	cover property (op_refused);
	cover property ($rose(erase_fail_flag));
	cover property (go && op_kind == OP_CLEAR && fl);
endmodule

// File: testbench/host_model.sv
// Host side that issues operation requests to the status block.
// Assumes go pulses from the bench; rude lets a scenario break order.
`timescale 1ns/100ps

module host_model
	import flash_status_pkg::*;
(
	input  wire logic     clk_sys,
	input  wire logic     rst,
	input  wire logic     go,
	input  wire op_kind_t kind,
	input  wire logic     rude,
	input  wire logic     fail_seen,
	output op_kind_t      op_kind,
	output logic          op_start
);
	// ----
	// Request issue
	// ----
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			op_start <= 1'b0;
			op_kind  <= OP_NONE;
		end
		else
		begin
			// Only clear after a failure, unless told to misbehave
			op_start <= go && (rude || !fail_seen || kind == OP_CLEAR);
			op_kind  <= go ? kind : OP_NONE;
		end
	end
endmodule
